// ### logic/pip_pkg.sv
// constants for the peripheral interrupt priority controller
package pip_pkg;
	localparam int          LVL_W          = 4;
	localparam int          CODE_W         = 12;
	localparam int          NSRC           = 10;
	localparam int          NMI_LEVEL      = 16;
	// register byte offsets on the bus
	localparam logic [3:0]  OFF_PRIO_A     = 4'h0;
	localparam logic [3:0]  OFF_PRIO_B     = 4'h4;
	localparam logic [3:0]  OFF_NMI_CTRL   = 4'h8;
	localparam logic [3:0]  OFF_EVENT      = 4'hC;
	localparam logic [15:0] PRIO_RESET     = 16'h0000;
	localparam logic [15:0] PRIO_B_WMASK   = 16'hFFF0;
	localparam int          NMI_LEVEL_BIT  = 15;
	localparam int          NMI_EDGE_BIT   = 8;
	// priority field positions (low bit of nibble)
	localparam int          FLD_RTC        = 0;
	localparam int          FLD_WDT        = 12;
	localparam int          FLD_REF        = 8;
	localparam int          FLD_SER        = 4;
	// event codes
	localparam logic [11:0] EV_NMI         = 12'h1C0;
	localparam logic [11:0] EV_ALARM       = 12'h480;
	localparam logic [11:0] EV_PERIODIC    = 12'h4A0;
	localparam logic [11:0] EV_CARRY       = 12'h4C0;
	localparam logic [11:0] EV_RX_ERR      = 12'h4E0;
	localparam logic [11:0] EV_RX_FULL     = 12'h500;
	localparam logic [11:0] EV_TX_EMPTY    = 12'h520;
	localparam logic [11:0] EV_TX_END      = 12'h540;
	localparam logic [11:0] EV_INTERVAL    = 12'h560;
	localparam logic [11:0] EV_REF_CMP     = 12'h580;
	localparam logic [11:0] EV_REF_OVF     = 12'h5A0;
	localparam logic [31:0] VECTOR_OFFSET  = 32'h00000600;
	// status word layout of the core
	localparam int          SW_MD_BIT      = 30;
	localparam int          SW_RB_BIT      = 29;
	localparam int          SW_BL_BIT      = 28;
	localparam int          SW_MASK_LO     = 4;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;
	localparam int          CLK_HZ         = 25000000;
endpackage

// ### logic/pip_ctrl.sv
// peripheral interrupt priority controller with axi4-lite registers
// Operation
// - clock alarm, periodic, carry codes, one field
// - serial error, full, empty, end codes
// - watchdog code 560, level from B top
// - refresh compare above overflow, shared field
// - ties resolved by fixed default order
// - priority registers 16-bit, reset zero
// - A fields: timers 0,1,2 then clock
// - B fields: watchdog, refresh, serial, zero
// - field value is level, zero masks
// - bit 15 reads live nonmaskable pin
// - bit 8 picks falling or rising edge
// - control register reset, reserved bits zero
// - pick highest level, keep others pending
// - forward only if level exceeds mask
// - pending output low while request beats mask
// - accept at boundary, load event code
// - save status and pc, set bits
// - jump to vector base plus 600
// - status mask field left unchanged
// - nested higher levels accepted after unblock
// - block bit holds off acceptance
`timescale 1ns/100ps
module pip_ctrl #(
	parameter int ADDR_W = 4
) (
	input  wire logic              clk_i,
	input  wire logic              reset_i,
	// axi4-lite slave
	input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	input  wire logic              s_axi_awvalid_i,
	output logic                   s_axi_awready_o,
	input  wire logic [31:0]       s_axi_wdata_i,
	input  wire logic [3:0]        s_axi_wstrb_i,
	input  wire logic              s_axi_wvalid_i,
	output logic                   s_axi_wready_o,
	output logic [1:0]             s_axi_bresp_o,
	output logic                   s_axi_bvalid_o,
	input  wire logic              s_axi_bready_i,
	input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input  wire logic              s_axi_arvalid_i,
	output logic                   s_axi_arready_o,
	output logic [31:0]            s_axi_rdata_o,
	output logic [1:0]             s_axi_rresp_o,
	output logic                   s_axi_rvalid_o,
	input  wire logic              s_axi_rready_i,
	// peripheral request levels
	input  wire logic              alarm_request_i,
	input  wire logic              periodic_request_i,
	input  wire logic              carry_up_request_i,
	input  wire logic              receive_error_request_i,
	input  wire logic              receive_full_request_i,
	input  wire logic              transmit_empty_request_i,
	input  wire logic              transmit_end_request_i,
	input  wire logic              interval_timer_request_i,
	input  wire logic              refresh_compare_request_i,
	input  wire logic              refresh_overflow_request_i,
	input  wire logic              nonmaskable_pin_i,
	// core side
	input  wire logic [31:0]       cpu_status_word_i,
	input  wire logic [31:0]       pc_i,
	input  wire logic [31:0]       vector_base_reg_i,
	input  wire logic              instr_boundary_i,
	output logic                   request_pending_out_n_o,
	output logic                   accept_o,
	output logic [11:0]            event_code_reg_o,
	output logic [31:0]            saved_status_reg_o,
	output logic [31:0]            saved_pc_reg_o,
	output logic [31:0]            new_status_word_o,
	output logic [31:0]            handler_pc_o
);
	// a narrower address could not reach the event code register
	if (ADDR_W < 4) begin : g_addr_chk
		$error("ADDR_W must be at least 4");
	end

	localparam logic [4:0] LVL_NMI = 5'(pip_pkg::NMI_LEVEL);

	// fixed default order: index 0 ranks highest
	function automatic logic [11:0] src_code(input int i);
		logic [11:0] c;
		c = pip_pkg::EV_ALARM;
		case (i)
			0: c = pip_pkg::EV_ALARM;
			1: c = pip_pkg::EV_PERIODIC;
			2: c = pip_pkg::EV_CARRY;
			3: c = pip_pkg::EV_RX_ERR;
			4: c = pip_pkg::EV_RX_FULL;
			5: c = pip_pkg::EV_TX_EMPTY;
			6: c = pip_pkg::EV_TX_END;
			7: c = pip_pkg::EV_INTERVAL;
			8: c = pip_pkg::EV_REF_CMP;
			default: c = pip_pkg::EV_REF_OVF;
		endcase
		return c;
	endfunction

	function automatic logic [3:0] nib(input logic [15:0] r, input int lo);
		return r[lo +: pip_pkg::LVL_W];
	endfunction

	// bus state
	logic        aw_have_reg, aw_have_next;
	logic        w_have_reg, w_have_next;
	logic [3:0]  aw_addr_reg, aw_addr_next;
	logic [31:0] w_data_reg, w_data_next;
	logic [3:0]  w_strb_reg, w_strb_next;
	logic        bvalid_reg, bvalid_next;
	logic [1:0]  bresp_reg, bresp_next;
	logic        rvalid_reg, rvalid_next;
	logic [1:0]  rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	// software registers
	logic [15:0] prio_a_reg, prio_a_next;
	logic [15:0] prio_b_reg, prio_b_next;
	logic        edge_sel_reg, edge_sel_next;
	// nonmaskable edge
	logic        nmi_prev_reg, nmi_prev_next;
	logic        nmi_pend_reg, nmi_pend_next;
	// decision stage
	logic [4:0]  sel_lvl_reg, sel_lvl_next;
	logic [11:0] sel_code_reg, sel_code_next;
	logic        sel_nmi_reg, sel_nmi_next;
	// acceptance outputs
	logic        acc_reg, acc_next;
	logic [11:0] ev_reg, ev_next;
	logic [31:0] ssr_reg, ssr_next;
	logic [31:0] spc_reg, spc_next;
	logic [31:0] nsw_reg, nsw_next;
	logic [31:0] hpc_reg, hpc_next;

	localparam int NSRC_W = pip_pkg::NSRC;
	logic [NSRC_W-1:0] req;
	logic [3:0]  cpu_mask;
	logic        cpu_block;
	logic        beats_mask;
	logic        take;
	logic        wr_go;
	logic        nmi_edge;
	logic [15:0] strb16;

	assign req = {refresh_overflow_request_i, refresh_compare_request_i,
		interval_timer_request_i, transmit_end_request_i,
		transmit_empty_request_i, receive_full_request_i,
		receive_error_request_i, carry_up_request_i,
		periodic_request_i, alarm_request_i};
	assign cpu_mask  = cpu_status_word_i[pip_pkg::SW_MASK_LO +: pip_pkg::LVL_W];
	assign cpu_block = cpu_status_word_i[pip_pkg::SW_BL_BIT];

	function automatic logic [3:0] src_level(input int i, input logic [15:0] a,
		input logic [15:0] b);
		logic [3:0] l;
		l = 4'h0;
		if (i < 3)
			l = nib(a, pip_pkg::FLD_RTC);
		else if (i < 7)
			l = nib(b, pip_pkg::FLD_SER);
		else if (i == 7)
			l = nib(b, pip_pkg::FLD_WDT);
		else
			l = nib(b, pip_pkg::FLD_REF);
		return l;
	endfunction

	// bus handshakes
	assign s_axi_awready_o = !aw_have_reg && !bvalid_reg;
	assign s_axi_wready_o  = !w_have_reg && !bvalid_reg;
	assign s_axi_arready_o = !rvalid_reg;
	assign s_axi_bvalid_o  = bvalid_reg;
	assign s_axi_bresp_o   = bresp_reg;
	assign s_axi_rvalid_o  = rvalid_reg;
	assign s_axi_rresp_o   = rresp_reg;
	assign s_axi_rdata_o   = rdata_reg;
	assign wr_go           = aw_have_reg && w_have_reg && !bvalid_reg;
	assign strb16          = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

	always_comb begin
		aw_have_next = aw_have_reg;
		w_have_next  = w_have_reg;
		aw_addr_next = aw_addr_reg;
		w_data_next  = w_data_reg;
		w_strb_next  = w_strb_reg;
		bvalid_next  = bvalid_reg;
		bresp_next   = bresp_reg;
		rvalid_next  = rvalid_reg;
		rresp_next   = rresp_reg;
		rdata_next   = rdata_reg;
		prio_a_next  = prio_a_reg;
		prio_b_next  = prio_b_reg;
		edge_sel_next = edge_sel_reg;
		if (s_axi_awvalid_i && s_axi_awready_o) begin
			aw_have_next = 1'b1;
			aw_addr_next = s_axi_awaddr_i[3:0];
		end
		if (s_axi_wvalid_i && s_axi_wready_o) begin
			w_have_next = 1'b1;
			w_data_next = s_axi_wdata_i;
			w_strb_next = s_axi_wstrb_i;
		end
		if (wr_go) begin
			aw_have_next = 1'b0;
			w_have_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = pip_pkg::RESP_OKAY;
			unique case (aw_addr_reg)
				pip_pkg::OFF_PRIO_A:
					prio_a_next = (prio_a_reg & ~strb16) |
						(w_data_reg[15:0] & strb16);
				pip_pkg::OFF_PRIO_B:
					prio_b_next = (prio_b_reg & ~(strb16 & pip_pkg::PRIO_B_WMASK)) |
						(w_data_reg[15:0] & strb16 & pip_pkg::PRIO_B_WMASK);
				pip_pkg::OFF_NMI_CTRL: begin
					if (w_strb_reg[1])
						edge_sel_next = w_data_reg[pip_pkg::NMI_EDGE_BIT];
				end
				pip_pkg::OFF_EVENT: ;
				default:
					bresp_next = pip_pkg::RESP_SLVERR;
			endcase
		end else if (bvalid_reg && s_axi_bready_i) begin
			bvalid_next = 1'b0;
		end
		if (s_axi_arvalid_i && s_axi_arready_o) begin
			rvalid_next = 1'b1;
			rresp_next  = pip_pkg::RESP_OKAY;
			rdata_next  = 32'h00000000;
			unique case (s_axi_araddr_i[3:0])
				pip_pkg::OFF_PRIO_A: rdata_next[15:0] = prio_a_reg;
				pip_pkg::OFF_PRIO_B: rdata_next[15:0] = prio_b_reg;
				pip_pkg::OFF_NMI_CTRL: begin
					// other bits stay zero
					rdata_next[pip_pkg::NMI_LEVEL_BIT] = nonmaskable_pin_i;
					rdata_next[pip_pkg::NMI_EDGE_BIT]  = edge_sel_reg;
				end
				pip_pkg::OFF_EVENT: rdata_next[11:0] = ev_reg;
				default: rresp_next = pip_pkg::RESP_SLVERR;
			endcase
		end else if (rvalid_reg && s_axi_rready_i) begin
			rvalid_next = 1'b0;
		end
	end

	// nonmaskable edge detection and latch
	assign nmi_edge = edge_sel_reg ? (nonmaskable_pin_i && !nmi_prev_reg) :
		(!nonmaskable_pin_i && nmi_prev_reg);

	always_comb begin
		nmi_prev_next = nonmaskable_pin_i;
		nmi_pend_next = nmi_pend_reg;
		if (take && sel_nmi_reg)
			nmi_pend_next = 1'b0;
		// a fresh edge beats the clear on acceptance
		if (nmi_edge)
			nmi_pend_next = 1'b1;
	end

	// decision stage: one registered cycle, the interval software waits out
	always_comb begin
		logic [3:0] l;
		l = 4'h0;
		sel_lvl_next  = 5'h00;
		sel_code_next = 12'h000;
		sel_nmi_next  = 1'b0;
		for (int i = 0; i < pip_pkg::NSRC; i++) begin
			l = src_level(i, prio_a_reg, prio_b_reg);
			// strict compare: earlier index keeps ties
			if (req[i] && ({1'b0, l} > sel_lvl_next)) begin
				sel_lvl_next  = {1'b0, l};
				sel_code_next = src_code(i);
			end
		end
		if (nmi_pend_reg) begin
			sel_lvl_next  = LVL_NMI;
			sel_code_next = pip_pkg::EV_NMI;
			sel_nmi_next  = 1'b1;
		end
	end

	// level zero never beats mask zero, so it stays masked
	assign beats_mask = sel_lvl_reg > {1'b0, cpu_mask};
	// pin ignores the block bit
	assign request_pending_out_n_o = !beats_mask;
	// lower requests stay on their inputs, nothing is discarded
	assign take = beats_mask && !cpu_block && instr_boundary_i && !acc_reg;

	always_comb begin
		acc_next = take;
		ev_next  = ev_reg;
		ssr_next = ssr_reg;
		spc_next = spc_reg;
		nsw_next = nsw_reg;
		hpc_next = hpc_reg;
		if (take) begin
			ev_next  = sel_code_reg;
			ssr_next = cpu_status_word_i;
			spc_next = pc_i;
			nsw_next = cpu_status_word_i;   // mask bits pass through
			nsw_next[pip_pkg::SW_BL_BIT] = 1'b1;
			nsw_next[pip_pkg::SW_MD_BIT] = 1'b1;
			nsw_next[pip_pkg::SW_RB_BIT] = 1'b1;
			hpc_next = vector_base_reg_i + pip_pkg::VECTOR_OFFSET;
		end
	end

	assign accept_o           = acc_reg;
	assign event_code_reg_o   = ev_reg;
	assign saved_status_reg_o = ssr_reg;
	assign saved_pc_reg_o     = spc_reg;
	assign new_status_word_o  = nsw_reg;
	assign handler_pc_o       = hpc_reg;

	// no standby input: only reset_i clears state
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			aw_have_reg  <= 1'b0;
			w_have_reg   <= 1'b0;
			aw_addr_reg  <= 4'h0;
			w_data_reg   <= 32'h00000000;
			w_strb_reg   <= 4'h0;
			bvalid_reg   <= 1'b0;
			bresp_reg    <= pip_pkg::RESP_OKAY;
			rvalid_reg   <= 1'b0;
			rresp_reg    <= pip_pkg::RESP_OKAY;
			rdata_reg    <= 32'h00000000;
			prio_a_reg   <= pip_pkg::PRIO_RESET;
			prio_b_reg   <= pip_pkg::PRIO_RESET;
			edge_sel_reg <= 1'b0;
			nmi_prev_reg <= 1'b1;
			nmi_pend_reg <= 1'b0;
			sel_lvl_reg  <= 5'h00;
			sel_code_reg <= 12'h000;
			sel_nmi_reg  <= 1'b0;
			acc_reg      <= 1'b0;
			ev_reg       <= 12'h000;
			ssr_reg      <= 32'h00000000;
			spc_reg      <= 32'h00000000;
			nsw_reg      <= 32'h00000000;
			hpc_reg      <= 32'h00000000;
		end else begin
			aw_have_reg  <= aw_have_next;
			w_have_reg   <= w_have_next;
			aw_addr_reg  <= aw_addr_next;
			w_data_reg   <= w_data_next;
			w_strb_reg   <= w_strb_next;
			bvalid_reg   <= bvalid_next;
			bresp_reg    <= bresp_next;
			rvalid_reg   <= rvalid_next;
			rresp_reg    <= rresp_next;
			rdata_reg    <= rdata_next;
			prio_a_reg   <= prio_a_next;
			prio_b_reg   <= prio_b_next;
			edge_sel_reg <= edge_sel_next;
			nmi_prev_reg <= nmi_prev_next;
			nmi_pend_reg <= nmi_pend_next;
			sel_lvl_reg  <= sel_lvl_next;
			sel_code_reg <= sel_code_next;
			sel_nmi_reg  <= sel_nmi_next;
			acc_reg      <= acc_next;
			ev_reg       <= ev_next;
			ssr_reg      <= ssr_next;
			spc_reg      <= spc_next;
			nsw_reg      <= nsw_next;
			hpc_reg      <= hpc_next;
		end
	end
endmodule

// ### tb/pip_ctrl_asserts.sv
// port assertions for the interrupt priority controller
`timescale 1ns/100ps
module pip_ctrl_asserts (
	input wire logic        clk_i,
	input wire logic        reset_i,
	input wire logic [31:0] cpu_status_word_i,
	input wire logic [31:0] pc_i,
	input wire logic [31:0] vector_base_reg_i,
	input wire logic        instr_boundary_i,
	input wire logic        request_pending_out_n_o,
	input wire logic        accept_o,
	input wire logic [31:0] saved_status_reg_o,
	input wire logic [31:0] saved_pc_reg_o,
	input wire logic [31:0] new_status_word_o,
	input wire logic [31:0] handler_pc_o
);
	wire logic bl = cpu_status_word_i[pip_pkg::SW_BL_BIT];
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (reset_i);
	a_accept_pulse: assert property (accept_o |=> !accept_o)
		else $error("accept held two cycles");
	a_accept_gate: assert property (accept_o |-> $past(instr_boundary_i) && !$past(bl))
		else $error("accept off boundary or while blocked");
	a_accept_level: assert property (accept_o |-> !$past(request_pending_out_n_o))
		else $error("accept without a request above mask");
	a_saved_state: assert property (accept_o |-> saved_pc_reg_o == $past(pc_i)
		&& saved_status_reg_o == $past(cpu_status_word_i)) else $error("saved state wrong");
	a_bits_set: assert property (accept_o |-> new_status_word_o[30:28] == 3'h7)
		else $error("block, mode or bank bit not set");
	a_mask_kept: assert property (accept_o |-> new_status_word_o[7:4] == saved_status_reg_o[7:4])
		else $error("mask field changed");
	a_handler_pc: assert property (accept_o |->
		handler_pc_o == $past(vector_base_reg_i) + pip_pkg::VECTOR_OFFSET) else $error("bad vector");
	a_results_hold: assert property (!accept_o |-> $stable(handler_pc_o) && $stable(saved_pc_reg_o))
		else $error("results moved without accept");
endmodule
bind pip_ctrl pip_ctrl_asserts pip_ctrl_asserts_i (.clk_i, .reset_i, .cpu_status_word_i, .pc_i,
	.vector_base_reg_i, .instr_boundary_i, .request_pending_out_n_o, .accept_o,
	.saved_status_reg_o, .saved_pc_reg_o, .new_status_word_o, .handler_pc_o);

// ### tb/pip_core_model.sv
// core side model: status word, block bit, boundaries
`timescale 1ns/100ps
module pip_core_model (
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic       accept_i,
	input  wire logic       unblock_i,
	input  wire logic       hold_i,
	input  wire logic       slow_i,
	input  wire logic [3:0] mask_i,
	output logic [31:0]     status_o,
	output logic [31:0]     pc_o,
	output logic            boundary_o
);
	logic       bl_reg;
	logic [1:0] cnt_reg;
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			bl_reg <= 1'h0;
			cnt_reg <= 2'h0;
			pc_o <= 32'h0;
		end else begin
			bl_reg <= accept_i | (bl_reg & ~unblock_i);
			cnt_reg <= (cnt_reg == 2'h2) ? 2'h0 : cnt_reg + 2'h1;
			pc_o <= pc_o + 32'h2;
		end
	end
	// hold keeps block up while levels change
	assign status_o = {3'h0, bl_reg | hold_i, 20'h0, mask_i, 4'h0};
	// slow mode: boundary only every third cycle
	assign boundary_o = ~slow_i | (cnt_reg == 2'h0);
endmodule

// ### tb/test_pip_ctrl.sv
// self-checking bench for the interrupt priority controller
`timescale 1ns/100ps
module test_pip_ctrl;
	localparam logic [3:0] PA = pip_pkg::OFF_PRIO_A, PB = pip_pkg::OFF_PRIO_B;
	localparam logic [3:0] PC = pip_pkg::OFF_NMI_CTRL;
	localparam logic [1:0] OK = pip_pkg::RESP_OKAY, ER = pip_pkg::RESP_SLVERR;
	// default order, highest first
	localparam logic [11:0] CODES [10] = '{pip_pkg::EV_ALARM, pip_pkg::EV_PERIODIC,
		pip_pkg::EV_CARRY, pip_pkg::EV_RX_ERR, pip_pkg::EV_RX_FULL, pip_pkg::EV_TX_EMPTY,
		pip_pkg::EV_TX_END, pip_pkg::EV_INTERVAL, pip_pkg::EV_REF_CMP, pip_pkg::EV_REF_OVF};
	logic        clk_i = 1'h0, reset_i = 1'h1, nonmaskable_pin_i = 1'h1;
	logic        s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0;
	logic        s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0;
	logic        unblock_i = 1'h0, hold_i = 1'h0, slow_i = 1'h0;
	logic [3:0]  s_axi_awaddr_i = 4'h0, s_axi_araddr_i = 4'h0, mask_i = 4'h0;
	logic [9:0]  req = 10'h000;
	logic [31:0] s_axi_wdata_i = 32'h0;
	logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
	logic        s_axi_rvalid_o, instr_boundary_i, request_pending_out_n_o, accept_o;
	logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
	logic [11:0] event_code_reg_o;
	logic [31:0] s_axi_rdata_o, cpu_status_word_i, pc_i;
	int          n_fail = 0, n_tests = 0;
	pip_ctrl #(.ADDR_W(4)) pip_ctrl_i (.clk_i, .reset_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
		.s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i, .s_axi_wready_o,
		.s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
		.s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
		.alarm_request_i(req[0]), .periodic_request_i(req[1]), .carry_up_request_i(req[2]),
		.receive_error_request_i(req[3]), .receive_full_request_i(req[4]),
		.transmit_empty_request_i(req[5]), .transmit_end_request_i(req[6]),
		.interval_timer_request_i(req[7]), .refresh_compare_request_i(req[8]),
		.refresh_overflow_request_i(req[9]), .nonmaskable_pin_i, .cpu_status_word_i, .pc_i,
		.vector_base_reg_i(32'h00001000), .instr_boundary_i, .request_pending_out_n_o,
		.accept_o, .event_code_reg_o, .saved_status_reg_o(), .saved_pc_reg_o(),
		.new_status_word_o(), .handler_pc_o());
	pip_core_model pip_core_model_i (.clk_i, .reset_i, .accept_i(accept_o), .unblock_i, .hold_i,
		.slow_i, .mask_i, .status_o(cpu_status_word_i), .pc_o(pc_i), .boundary_o(instr_boundary_i));
	initial begin
		forever #20 clk_i = ~clk_i;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic hang();
		n_fail++;
		$display("[FAIL] %0t no answer", $time);
		complete_run();
	endtask
	// one bus cycle; valids drop only at the edge that takes them
	task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
		input logic [1:0] e);
		logic        ta, tw, dn;
		logic [31:0] v;
		logic [1:0]  r;
		@(posedge clk_i);
		s_axi_awaddr_i <= a;
		s_axi_araddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= w;
		s_axi_wvalid_i <= w;
		s_axi_bready_i <= w;
		s_axi_arvalid_i <= !w;
		s_axi_rready_i <= !w;
		dn = 1'h0;
		for (int n = 0; n < 40 && !dn; n++) begin
			@(negedge clk_i);
			ta = w ? s_axi_awready_o : s_axi_arready_o;
			tw = s_axi_wready_o;
			dn = w ? s_axi_bvalid_o : s_axi_rvalid_o;
			r = w ? s_axi_bresp_o : s_axi_rresp_o;
			v = s_axi_rdata_o;
			@(posedge clk_i);
			if (ta) s_axi_awvalid_i <= 1'h0;
			if (ta) s_axi_arvalid_i <= 1'h0;
			if (tw) s_axi_wvalid_i <= 1'h0;
		end
		if (!dn) hang();
		s_axi_bready_i <= 1'h0;
		s_axi_rready_i <= 1'h0;
		chk(32'(r), 32'(e));
		if (!w) chk(v, d);
	endtask
	task automatic wacc(input logic [11:0] e);
		logic got;
		got = 1'h0;
		for (int n = 0; n < 30 && !got; n++) begin
			@(negedge clk_i);
			got = (accept_o === 1'h1);
			if (got) chk(32'(event_code_reg_o), 32'(e));
			@(posedge clk_i);
		end
		if (!got) hang();
	endtask
	task automatic quiet(input logic p);
		int k;
		k = 0;
		for (int n = 0; n < 12; n++) begin
			@(negedge clk_i);
			k += (accept_o !== 1'h0);
		end
		chk(32'(k), 32'h0);
		chk(32'(request_pending_out_n_o), 32'(p));
		@(posedge clk_i);
	endtask
	// handler waits past the decision interval before unblocking
	task automatic ub();
		repeat (2) @(posedge clk_i);
		unblock_i <= 1'h1;
		@(posedge clk_i);
		unblock_i <= 1'h0;
	endtask
	task automatic setp(input logic [15:0] a, input logic [15:0] b);
		hold_i <= 1'h1;
		xfer(1'h1, PA, {16'h0000, a}, OK);
		xfer(1'h1, PB, {16'h0000, b}, OK);
		xfer(1'h0, PB, {16'h0000, b & 16'hFFF0}, OK);
		hold_i <= 1'h0;
	endtask
	task automatic t_regs();
		xfer(1'h0, PA, 32'h0, OK);
		xfer(1'h0, PC, 32'h00008000, OK);
		setp(16'hFFFF, 16'hFFF0);
		xfer(1'h0, PA, 32'h0000FFFF, OK);
		xfer(1'h1, PC, 32'h0000FFFF, OK);
		xfer(1'h0, PC, 32'h00008100, OK);
		nonmaskable_pin_i <= 1'h0;
		xfer(1'h0, PC, 32'h00000100, OK);
		xfer(1'h1, 4'h6, 32'h00001234, ER);
		xfer(1'h0, 4'h6, 32'h0, ER);
		$display("t_regs done");
	endtask
	task automatic t_nmi();
		slow_i <= 1'h1;
		mask_i <= 4'hF;
		// the falling edge made in rising mode must not have been taken
		quiet(1'h1);
		nonmaskable_pin_i <= 1'h1;
		wacc(pip_pkg::EV_NMI);
		ub();
		xfer(1'h1, PC, 32'h0, OK);
		nonmaskable_pin_i <= 1'h0;
		@(posedge clk_i);
		nonmaskable_pin_i <= 1'h1;
		wacc(pip_pkg::EV_NMI);
		ub();
		slow_i <= 1'h0;
		$display("t_nmi done");
	endtask
	task automatic t_rank();
		mask_i <= 4'h0;
		setp(16'h0005, 16'h5550);
		req <= 10'h3FF;
		for (int i = 0; i < 10; i++) begin
			wacc(CODES[i]);
			req[i] <= 1'h0;
			ub();
		end
		$display("t_rank done");
	endtask
	task automatic t_mask();
		setp(16'h0000, 16'h7900);
		mask_i <= 4'h7;
		req <= 10'h181;
		wacc(pip_pkg::EV_REF_CMP);
		req[8] <= 1'h0;
		quiet(1'h1);
		mask_i <= 4'h6;
		quiet(1'h0);
		ub();
		wacc(pip_pkg::EV_INTERVAL);
		req[7] <= 1'h0;
		xfer(1'h0, pip_pkg::OFF_EVENT, {20'h00000, pip_pkg::EV_INTERVAL}, OK);
		ub();
		mask_i <= 4'h0;
		quiet(1'h1);
		$display("t_mask done");
	endtask
	initial begin
		repeat (8) @(posedge clk_i);
		reset_i <= 1'h0;
		t_regs();
		t_nmi();
		t_rank();
		t_mask();
		complete_run();
	end
endmodule
